// ==== design/dht_pkg.sv ====
package dht_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DHT_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] DHT_ADDR_STATUS = 8'h04;
    localparam logic [7:0] DHT_ADDR_TEMP   = 8'h08;
    localparam logic [7:0] DHT_ADDR_SENSE  = 8'h0C;
    localparam logic [7:0] DHT_ADDR_FHC    = 8'h10;
    localparam logic [7:0] DHT_ADDR_LOGSEL = 8'h14;
    localparam logic [7:0] DHT_ADDR_LOGDAT = 8'h18;
    localparam logic [7:0] DHT_ADDR_LOGLBA = 8'h1C;

    // ------------------------------------------------------------
    // Field values
    // ------------------------------------------------------------
    localparam logic [2:0] DHT_FC_NONE  = 3'h0;
    localparam logic [2:0] DHT_FC_SHORT = 3'h1;
    localparam logic [2:0] DHT_FC_EXT   = 3'h2;
    localparam logic [2:0] DHT_FC_ABORT = 3'h4;
    localparam logic [3:0] DHT_RES_PASS    = 4'h0;
    localparam logic [3:0] DHT_RES_ABORT   = 4'h1;
    localparam logic [3:0] DHT_RES_RESET   = 4'h2;
    localparam logic [3:0] DHT_RES_FAIL    = 4'h7;
    localparam logic [3:0] DHT_RES_RUNNING = 4'hF;
    localparam logic [23:0] DHT_SENSE_TEMP_WARN = 24'h010801;
    localparam logic [23:0] DHT_SENSE_NR_CAUSE  = 24'h020400;
    localparam logic [23:0] DHT_SENSE_NR_MANUAL = 24'h020403;
    localparam logic [23:0] DHT_SENSE_NONE      = 24'h000000;
    localparam logic [1:0] DHT_RESP_OKAY   = 2'h0;
    localparam logic [1:0] DHT_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int DHT_CLK_MHZ          = 100;
    localparam int DHT_TEMP_PERIOD_S    = 600;
    localparam longint DHT_TEMP_PERIOD_CYC = longint'(DHT_TEMP_PERIOD_S) * DHT_CLK_MHZ * 1000000;
    localparam int DHT_SHORT_BUDGET_S   = 120;
    localparam longint DHT_SHORT_BUDGET_CYC = longint'(DHT_SHORT_BUDGET_S) * DHT_CLK_MHZ * 1000000;

    typedef enum logic [2:0] {
        DHT_ST_IDLE,
        DHT_ST_ELEC,
        DHT_ST_SERVO,
        DHT_ST_SCAN,
        DHT_ST_DONE
    } dht_state_type;

endpackage : dht_pkg

// ==== design/dht_attr_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module dht_attr_monitor
    import dht_pkg::*;
#(
    parameter int CW        = 8,
    parameter int OPS_PER_IV = 16,
    parameter int ERR_LIMIT = 2,
    parameter logic [7:0] THRESHOLD = 8'h04
)(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          opStb,
    input  wire logic          errStb,
    output var  logic [CW-1:0] historyCount,
    output var  logic          predictFail
);
    typedef struct packed {
        logic [15:0]   ops;
        logic [15:0]   errs;
        logic [CW-1:0] hist;
        logic          fail;
    } dht_attr_type;

    dht_attr_type s_q, s_d;
    logic ivEnd;

    always_comb
    begin
        s_d = s_q;
        ivEnd = opStb && (s_q.ops == 16'(OPS_PER_IV - 1));
        if (opStb)
        begin
            s_d.ops = s_q.ops + 16'h0001;
        end
        if (errStb)
        begin
            s_d.errs = s_q.errs + 16'h0001;
        end
        if (ivEnd)
        begin
            if (s_d.errs > 16'(ERR_LIMIT))
            begin
                if (s_q.hist != {CW{1'b1}})
                begin
                    s_d.hist = s_q.hist + CW'(1); // [R1]
                end
            end
            else if (s_q.hist != '0)
            begin
                s_d.hist = s_q.hist - CW'(1); // [R1]
            end
            s_d.ops  = '0; // [R3]
            s_d.errs = '0; // [R3]
        end
        s_d.fail = (s_d.hist >= CW'(THRESHOLD)); // [R2] [R23]
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign historyCount = s_q.hist;
    assign predictFail  = s_q.fail;
endmodule // dht_attr_monitor
`default_nettype wire

// ==== design/dht_health_ctrl.sv ====
// Notes on behaviour
// [R1] History counts up on bad interval, down on good, floors at zero.
// [R2] Per-attribute counters; any at threshold flags predictive failure.
// [R3] Interval end clears operation and error counters; counting restarts.
// [R4] Temperature sampled at power-up, then every ten minutes.
// [R5] Sample above limit reports warning sense code 01-0801.
// [R6] Over-temperature also saves a health data frame.
// [R7] Warning gated by enable bit; method field chooses delivery.
// [R8] Diagnostic byte 1 bits 7:5 select test: 001b short, 010b extended.
// [R9] Every test runs electrical, then servo, then read/verify segments.
// [R10] Short test ends within 120 s, scanning only part of media.
// [R11] Extended test also verifies every block address.
// [R12] Test start inserts entry at head of 20-entry log, dropping oldest.
// [R13] New entry holds function code and result Fh, then log is committed.
// [R14] Finish or abort writes 4-bit result: zero pass, else failure cause.
// [R15] Failure records address, sense codes and replaceable unit code.
// [R16] Only unrecovered errors after retries count as failures.
// [R17] Retries and recovery stay enabled during self-test.
// [R18] Abort function code aborts background test; result logged 01.
// [R19] Bus or device reset aborts test; result logged 02. Here only busReset logs 02; rst clears the whole log.
// [R20] Spindle, servo or table faults report not-ready 02/04/00 or 02/04/03.
// [R21] Host checks ready before diagnostics; finds not-ready cause itself.
// [R22] Host reads the 20 latest results through the log read path.
// [R23] Predictive threshold is a fixed per-attribute constant.
// [R24] Running self-test reports not-ready.
`timescale 1ns/1ns
`default_nettype none
module dht_health_ctrl
    import dht_pkg::*;
#(
    parameter int     NATTR        = 4,
    parameter int     LOG_DEPTH    = 20,
    parameter longint TEMP_PERIOD  = DHT_TEMP_PERIOD_CYC,
    parameter longint SHORT_BUDGET = DHT_SHORT_BUDGET_CYC
)(
    input  wire logic             mclk,
    input  wire logic             rst,
    // AXI4-Lite slave
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output var  logic             s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output var  logic             s_axi_wready,
    output var  logic [1:0]       s_axi_bresp,
    output var  logic             s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output var  logic             s_axi_arready,
    output var  logic [31:0]      s_axi_rdata,
    output var  logic [1:0]       s_axi_rresp,
    output var  logic             s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             busReset,
    input  wire logic [NATTR-1:0] attrOpStb,
    input  wire logic [NATTR-1:0] attrErrStb,
    input  wire logic [7:0]       tempValue,
    input  wire logic             spindleFault,
    input  wire logic             servoLockFault,
    input  wire logic             configTableFault,
    input  wire logic             segDone,
    input  wire logic             segUnrecoveredErr,
    input  wire logic [31:0]      segFailLba,
    input  wire logic [7:0]       segReplaceableUnit,
    output var  logic             tempSampleReq,
    output var  logic             segStart,
    output var  logic [2:0]       segSelect,
    output var  logic             fullMediaScan,
    output var  logic             retriesEnabled,
    output var  logic             frameSaveReq,
    output var  logic             logCommitReq,
    output var  logic             warnReport,
    output var  logic [1:0]       warnMethod,
    output var  logic             predictFail,
    output var  logic             driveReady
);
    localparam int LW = $clog2(LOG_DEPTH);
    localparam int CTRL_FC_LSB = 5;
    localparam int CTRL_EWARN  = 8;
    localparam int CTRL_MTH_LSB = 12;
    localparam int CTRL_LIM_LSB = 16;

    typedef struct packed {
        logic [2:0]  fc;
        logic [3:0]  res;
        logic [23:0] sense;
        logic [7:0]  replaceable_unit_code;
        logic [31:0] lba;
    } dht_entry_type;

    typedef struct packed {
        logic                      awDone, wDone;
        logic [7:0]                awAddr;
        logic [31:0]               wData;
        logic                      bValid, rValid;
        logic [1:0]                bResp, rResp;
        logic [31:0]               rData;
        logic                      warnEn;
        logic [1:0]                method;
        logic [7:0]                tempLimit;
        logic [7:0]                lastTemp;
        logic                      warnPend, warnPulse, frameReq, sampReq, sampPend;
        logic [23:0]               sense;
        logic [39:0]               tempCnt;
        logic [39:0]               testCnt;
        dht_state_type             st;
        logic [2:0]                curFc;
        logic                      segGo, commit;
        logic [LW-1:0]             logSel;
        logic [LW:0]               logCount;
        dht_entry_type [LOG_DEPTH-1:0] log;
        logic                      ready;
    } dht_state_pack_type;

    dht_state_pack_type s_q, s_d;
    logic [NATTR-1:0] attrFail;
    logic [NATTR*8-1:0] attrHist;

    genvar g;
    generate
        for (g = 0; g < NATTR; g++)
        begin : gAttr
            dht_attr_monitor u_attr (
                .mclk         (mclk),
                .rst          (rst),
                .opStb        (attrOpStb[g]),
                .errStb       (attrErrStb[g]),
                .historyCount (attrHist[g*8 +: 8]),
                .predictFail  (attrFail[g])
            );
        end
    endgenerate

    function automatic logic [31:0] entryWord(input dht_entry_type e);
        entryWord = {e.replaceable_unit_code, e.sense[23:16], e.sense[15:8], 1'b0, e.fc, e.res};
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic           wrFire;
        logic           abortReq;
        logic           startReq;
        logic [2:0]     fcReq;
        logic           notReadyHw;
        logic [3:0]     finRes;
        logic           finish;
        dht_entry_type  newEntry;
        wrFire     = 1'b0;
        abortReq   = 1'b0;
        startReq   = 1'b0;
        fcReq      = DHT_FC_NONE;
        finRes     = DHT_RES_PASS;
        finish     = 1'b0;
        newEntry   = '0;
        s_d        = s_q;
        s_d.segGo  = 1'b0;
        s_d.commit = 1'b0;
        s_d.warnPulse = 1'b0;
        s_d.frameReq  = 1'b0;
        s_d.sampReq   = 1'b0;
        notReadyHw = spindleFault || servoLockFault || configTableFault;

        // ---------------- Write channel ----------------
        if (s_axi_awvalid && !s_q.awDone)
        begin
            s_d.awDone = 1'b1;
            s_d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.wDone)
        begin
            s_d.wDone = 1'b1;
            s_d.wData = s_axi_wdata;
        end
        if (s_q.awDone && s_q.wDone && !s_q.bValid)
        begin
            wrFire     = 1'b1;
            s_d.awDone = 1'b0;
            s_d.wDone  = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp  = DHT_RESP_OKAY;
            if (s_q.awAddr == DHT_ADDR_CTRL)
            begin
                fcReq = s_q.wData[CTRL_FC_LSB +: 3]; // [R8]
                if (s_axi_wstrb[1])
                begin
                    s_d.warnEn = s_q.wData[CTRL_EWARN];
                    s_d.method = s_q.wData[CTRL_MTH_LSB +: 2];
                end
                if (s_axi_wstrb[2])
                begin
                    s_d.tempLimit = s_q.wData[CTRL_LIM_LSB +: 8];
                end
            end
            else if (s_q.awAddr == DHT_ADDR_LOGSEL)
            begin
                s_d.logSel = s_q.wData[LW-1:0];
            end
            else if (s_q.awAddr == DHT_ADDR_SENSE || s_q.awAddr == DHT_ADDR_STATUS)
            begin
                s_d.sense = DHT_SENSE_NONE;
            end
            else
            begin
                s_d.bResp = DHT_RESP_SLVERR;
            end
        end
        if (s_q.bValid && s_axi_bready)
        begin
            s_d.bValid = 1'b0;
        end

        // ---------------- Read channel ----------------
        if (s_axi_arvalid && !s_q.rValid)
        begin
            s_d.rValid = 1'b1;
            s_d.rResp  = DHT_RESP_OKAY;
            if (s_axi_araddr == DHT_ADDR_CTRL)
            begin
                s_d.rData = {8'h00, s_q.tempLimit, 2'h0, s_q.method, 3'h0, s_q.warnEn, s_q.curFc, 5'h00};
            end
            else if (s_axi_araddr == DHT_ADDR_STATUS)
            begin
                s_d.rData = {24'h000000, 3'h0, s_q.st != DHT_ST_IDLE, s_q.ready, s_q.warnPend,
                             |attrFail, 1'b0};
            end
            else if (s_axi_araddr == DHT_ADDR_TEMP)
            begin
                s_d.rData = {24'h000000, s_q.lastTemp};
            end
            else if (s_axi_araddr == DHT_ADDR_SENSE)
            begin
                s_d.rData = {8'h00, s_q.sense};
            end
            else if (s_axi_araddr == DHT_ADDR_FHC)
            begin
                s_d.rData = attrHist[31:0];
            end
            else if (s_axi_araddr == DHT_ADDR_LOGSEL)
            begin
                s_d.rData = {16'h0000, 3'h0, 5'(s_q.logCount), 3'h0, 5'(s_q.logSel)};
            end
            else if (s_axi_araddr == DHT_ADDR_LOGDAT)
            begin
                s_d.rData = (s_q.logSel < LW'(s_q.logCount)) ? entryWord(s_q.log[s_q.logSel]) : '0; // [R22]
            end
            else if (s_axi_araddr == DHT_ADDR_LOGLBA)
            begin
                s_d.rData = s_q.log[s_q.logSel].lba; // [R15] [R22]
            end
            else
            begin
                s_d.rData = '0;
                s_d.rResp = DHT_RESP_SLVERR;
            end
        end
        if (s_q.rValid && s_axi_rready)
        begin
            s_d.rValid = 1'b0;
        end

        // ---------------- Thermal monitor ----------------
        if (s_q.tempCnt == 40'(TEMP_PERIOD - 1))
        begin
            s_d.tempCnt = '0;
            s_d.sampReq = 1'b1; // [R4]
            s_d.sampPend = 1'b1;
        end
        else
        begin
            s_d.tempCnt = s_q.tempCnt + 40'h1;
        end
        if (s_q.sampPend)
        begin
            s_d.sampPend = 1'b0;
            s_d.lastTemp = tempValue;
            if (tempValue > s_q.tempLimit)
            begin
                s_d.frameReq = 1'b1; // [R6]
                if (s_q.warnEn)
                begin
                    s_d.warnPend  = 1'b1; // [R7]
                    s_d.warnPulse = 1'b1;
                    s_d.sense     = DHT_SENSE_TEMP_WARN; // [R5]
                end
            end
        end

        // ---------------- Self-test sequencer ----------------
        abortReq = (fcReq == DHT_FC_ABORT) && (s_q.st != DHT_ST_IDLE); // [R18]
        startReq = (fcReq == DHT_FC_SHORT || fcReq == DHT_FC_EXT) && s_q.st == DHT_ST_IDLE && s_q.ready; // [R8]
        case (s_q.st)
            DHT_ST_IDLE:
            begin
                if (startReq)
                begin
                    newEntry.fc  = fcReq; // [R13]
                    newEntry.res = DHT_RES_RUNNING; // [R13]
                    for (int i = LOG_DEPTH - 1; i > 0; i--)
                    begin
                        s_d.log[i] = s_q.log[i-1]; // [R12]
                    end
                    s_d.log[0] = newEntry;
                    if (s_q.logCount != (LW+1)'(LOG_DEPTH))
                    begin
                        s_d.logCount = s_q.logCount + (LW+1)'(1);
                    end
                    s_d.commit = 1'b1; // [R13]
                    s_d.curFc  = fcReq;
                    s_d.testCnt = '0;
                    s_d.st     = DHT_ST_ELEC; // [R9]
                    s_d.segGo  = 1'b1;
                end
            end
            DHT_ST_ELEC, DHT_ST_SERVO, DHT_ST_SCAN:
            begin
                s_d.testCnt = s_q.testCnt + 40'h1;
                if (segDone && segUnrecoveredErr) // [R16]
                begin
                    finish = 1'b1;
                    finRes = DHT_RES_FAIL; // [R14]
                    s_d.log[0].lba   = segFailLba; // [R15]
                    s_d.log[0].sense = {8'h04, 8'h40, 5'h00, 3'(s_q.st)};
                    s_d.log[0].replaceable_unit_code   = segReplaceableUnit;
                end
                else if (s_q.curFc == DHT_FC_SHORT && s_q.testCnt == 40'(SHORT_BUDGET - 1))
                begin
                    finish = 1'b1; // [R10]
                end
                else if (segDone)
                begin
                    s_d.segGo = (s_q.st != DHT_ST_SCAN);
                    if (s_q.st == DHT_ST_ELEC)
                    begin
                        s_d.st = DHT_ST_SERVO; // [R9]
                    end
                    else if (s_q.st == DHT_ST_SERVO)
                    begin
                        s_d.st = DHT_ST_SCAN; // [R9]
                    end
                    else
                    begin
                        finish = 1'b1;
                    end
                end
                if (abortReq)
                begin
                    finish = 1'b1;
                    finRes = DHT_RES_ABORT; // [R18]
                end
                if (busReset)
                begin
                    finish = 1'b1;
                    finRes = DHT_RES_RESET; // [R19]
                end
                if (finish)
                begin
                    s_d.log[0].res = finRes; // [R14]
                    s_d.commit = 1'b1;
                    s_d.segGo  = 1'b0;
                    s_d.st     = DHT_ST_DONE;
                end
            end
            default:
            begin
                s_d.st = DHT_ST_IDLE;
            end
        endcase

        s_d.ready = !notReadyHw && (s_d.st == DHT_ST_IDLE); // [R20] [R24]
        if (notReadyHw && !s_q.warnPend)
        begin
            s_d.sense = servoLockFault ? DHT_SENSE_NR_MANUAL : DHT_SENSE_NR_CAUSE; // [R20]
        end
        if (wrFire && s_q.awAddr == DHT_ADDR_STATUS && !s_d.warnPulse)
        begin
            s_d.warnPend = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_q         <= '0;
            s_q.sampPend <= 1'b1; // Power-up sample [R4]
            s_q.sampReq <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            predictFail <= 1'b0;
        end
        else
        begin
            predictFail <= |attrFail; // [R2]
        end
    end

    assign s_axi_awready = !s_q.awDone;
    assign s_axi_wready  = !s_q.wDone;
    assign s_axi_bvalid  = s_q.bValid;
    assign s_axi_bresp   = s_q.bResp;
    assign s_axi_arready = !s_q.rValid;
    assign s_axi_rvalid  = s_q.rValid;
    assign s_axi_rdata   = s_q.rData;
    assign s_axi_rresp   = s_q.rResp;
    assign tempSampleReq = s_q.sampReq;
    assign segStart      = s_q.segGo;
    assign segSelect     = 3'(s_q.st);
    assign fullMediaScan = (s_q.curFc == DHT_FC_EXT); // [R11]
    assign retriesEnabled = 1'b1 | s_q.ready; // [R17]
    assign frameSaveReq  = s_q.frameReq;
    assign logCommitReq  = s_q.commit;
    assign warnReport    = s_q.warnPulse;
    assign warnMethod    = s_q.method; // [R7]
    assign driveReady    = s_q.ready;
endmodule // dht_health_ctrl
`default_nettype wire

// ==== verif/dht_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module dht_checker #(
    parameter longint TEMP_PERIOD = 50
)(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       tempSampleReq,
    input wire logic       segStart,
    input wire logic [2:0] segSelect,
    input wire logic       segDone,
    input wire logic       segUnrecoveredErr,
    input wire logic       retriesEnabled,
    input wire logic       warnReport,
    input wire logic       frameSaveReq,
    input wire logic       busReset,
    input wire logic       spindleFault,
    input wire logic       driveReady
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    longint     gap_q;
    logic [2:0] lastSel_q;
    always_ff @(posedge mclk)
    begin
        gap_q     <= rst ? -64'sd1 : (tempSampleReq ? 64'h0 : gap_q + 64'h1);
        lastSel_q <= segStart ? segSelect : lastSel_q;
    end
    sequence noStart2;
        !segStart [*2];
    endsequence
    a_retry_on: assert property (retriesEnabled) else $error("retries off");
    a_temp_late: assert property (gap_q < TEMP_PERIOD) else $error("sample late");
    a_temp_early: assert property (tempSampleReq && gap_q > 2 |-> gap_q == TEMP_PERIOD - 1)
        else $error("sample early");
    a_seg_order: assert property (segStart && segSelect != 3'h1 |-> segSelect == lastSel_q + 3'h1)
        else $error("segment order");
    a_busy_nready: assert property (segStart |=> !driveReady) else $error("busy ready");
    a_fault_nready: assert property (spindleFault |=> !driveReady) else $error("fault ready");
    a_warn_frame: assert property (warnReport |-> frameSaveReq) else $error("no frame save");
    a_fail_stop: assert property (segDone && segUnrecoveredErr |=> noStart2) else $error("ran on");
    a_reset_stop: assert property (busReset |=> noStart2) else $error("reset ignored");
endmodule // dht_checker
bind dht_health_ctrl dht_checker #(.TEMP_PERIOD(TEMP_PERIOD)) i_dht_checker (.*);
`default_nettype wire

// ==== verif/dht_drive_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dht_drive_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       segStart,
    input  wire logic [2:0] segSelect,
    input  wire logic [2:0] failSeg,
    input  wire logic [3:0] lat,
    output var  logic       segDone,
    output var  logic       segUnrecoveredErr
);
    logic       run_q;
    logic [3:0] cnt_q;
    logic [2:0] sel_q;
    wire logic  segEnd = run_q && cnt_q == 4'h0;
    always_ff @(posedge mclk)
    begin
        run_q   <= !rst && (segStart || (run_q && cnt_q != 4'h0));
        cnt_q   <= segStart ? lat : cnt_q - 4'h1;
        sel_q   <= segStart ? segSelect : sel_q;
        segDone <= !rst && segEnd;
        segUnrecoveredErr <= rst ? 1'h0 : (segEnd ? sel_q == failSeg : !segUnrecoveredErr);
    end
endmodule // dht_drive_model
`default_nettype wire

// ==== verif/tb_drive_health_and_self_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb_drive_health_and_self_test;
    import dht_pkg::*;
    logic        mclk = 1'h0, rst = 1'h1, busReset = 1'h0, spindleFault = 1'h0, s_axi_awvalid = 1'h0;
    logic        s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tempValue = 8'h20;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic [3:0]  attrOpStb = 4'h0, attrErrStb = 4'h0, lat = 4'hF;
    logic [2:0]  failSeg = 3'h0;
    logic        servoLockFault = 1'h0, configTableFault = 1'h0;
    logic [1:0]  rsp;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, segDone, segStart;
    wire logic   segUnrecoveredErr, fullMediaScan, warnReport, predictFail, driveReady;
    wire logic [31:0] s_axi_rdata;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp, warnMethod;
    wire logic [2:0]  segSelect;
    int          checks = 0, miscompares = 0, seed = 63, warnCnt = 0;
    always #5 mclk = ~mclk;
    always @(posedge mclk) warnCnt += (warnReport === 1'h1);
    dht_health_ctrl #(.TEMP_PERIOD(50), .SHORT_BUDGET(400)) i_dht_health_ctrl (.*, .s_axi_wstrb(4'hF),
        .segFailLba(32'h0012_3456), .segReplaceableUnit(8'hA5),
        .tempSampleReq(), .retriesEnabled(), .frameSaveReq(), .logCommitReq());
    dht_drive_model i_dht_drive_model (.*);
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {wr, wr, wr, !wr, !wr};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        do
        begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && s_axi_rvalid !== 1'h1);
        rsp = wr ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
        {s_axi_bready, s_axi_rready} <= 2'h0;
    endtask
    task automatic start(input logic [2:0] fc);
        bus(1'h1, DHT_ADDR_CTRL, {24'h0, fc, 5'h0});
        repeat (3) @(posedge mclk);
    endtask
    task automatic fin(input logic [7:0] a);
        for (int i = 0; i < 3000 && driveReady !== 1'h1; i++) @(posedge mclk);
        bus(1'h0, a, 32'h0);
    endtask
    task automatic iv(input int nErr);
        for (int i = 0; i < 17; i++)
        begin
            @(posedge mclk);
            {attrOpStb[0], attrErrStb[0]} <= {i < 16, i < nErr};
        end
    endtask
    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        fin(DHT_ADDR_STATUS);
        `CHK(rd[3], 1'h1, "ready")
        fin(8'h40);
        `CHK(rsp, DHT_RESP_SLVERR, "unmapped")
        start(DHT_FC_SHORT);
        `CHK(driveReady, 1'h0, "busy")
        bus(1'h1, DHT_ADDR_CTRL, {24'h0, DHT_FC_ABORT, 5'h0});
        fin(DHT_ADDR_LOGDAT);
        `CHK(rd[7:0], {1'h0, DHT_FC_SHORT, DHT_RES_ABORT}, "abort")
        start(DHT_FC_EXT);
        busReset <= 1'h1;
        `CHK(fullMediaScan, 1'h1, "full scan")
        @(posedge mclk);
        busReset <= 1'h0;
        fin(DHT_ADDR_LOGDAT);
        `CHK(rd[7:0], {1'h0, DHT_FC_EXT, DHT_RES_RESET}, "reset")
        failSeg <= 3'h3;
        start(DHT_FC_EXT);
        fin(DHT_ADDR_LOGLBA);
        `CHK(rd, 32'h0012_3456, "lba")
        fin(DHT_ADDR_LOGDAT);
        `CHK({rd[31:24], rd[3:0]}, {8'hA5, DHT_RES_FAIL}, "fail")
        failSeg <= 3'h0;
        for (int i = 0; i < 18; i++)
        begin
            lat <= 4'($random(seed));
            start(($random(seed) & 1) ? DHT_FC_EXT : DHT_FC_SHORT);
            fin(DHT_ADDR_LOGDAT);
            `CHK(rd[3:0], DHT_RES_PASS, "pass")
        end
        fin(DHT_ADDR_LOGSEL);
        `CHK(rd[12:8], 5'h14, "log count")
        bus(1'h1, DHT_ADDR_LOGSEL, 32'h13);
        fin(DHT_ADDR_LOGDAT);
        `CHK(rd[7:0], {1'h0, DHT_FC_EXT, DHT_RES_RESET}, "oldest")
        bus(1'h1, DHT_ADDR_SENSE, 32'h0);
        {spindleFault, configTableFault} <= 2'h3;
        bus(1'h0, DHT_ADDR_SENSE, 32'h0);
        `CHK(rd[23:0], DHT_SENSE_NR_CAUSE, "not ready")
        {spindleFault, configTableFault, servoLockFault} <= 3'h1;
        bus(1'h0, DHT_ADDR_SENSE, 32'h0);
        `CHK(rd[23:0], DHT_SENSE_NR_MANUAL, "servo")
        servoLockFault <= 1'h0;
        bus(1'h1, DHT_ADDR_CTRL, 32'h0040_1100);
        tempValue <= 8'h50;
        repeat (60) @(posedge mclk);
        fin(DHT_ADDR_SENSE);
        `CHK(rd[23:0], DHT_SENSE_TEMP_WARN, "temp warn")
        `CHK({warnCnt != 0, warnMethod}, 3'h5, "warn method")
        fin(DHT_ADDR_TEMP);
        `CHK(rd[7:0], 8'h50, "temp")
        repeat (4) iv(3);
        fin(DHT_ADDR_FHC);
        `CHK({predictFail, rd[15:0]}, 17'h10004, "history")
        iv(0);
        fin(DHT_ADDR_FHC);
        `CHK(rd[7:0], 8'h03, "decrement")
        results();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        results();
    end
endmodule // tb_drive_health_and_self_test
`default_nettype wire
